/* File: rtl/pvic_ctrl.sv */
// Overview of operation
// - Reset vector zero, sources 0003H step eight
// - Per-source enables, global enable masks all
// - Four levels; comparator fixed lowest
// - Preempt only by strictly higher level
// - Equal level ties go to lowest vector
// - Edge external flags cleared on vectoring
// - Timer flags cleared on vectoring, except mode3
// - Serial request ORs three flags, no clear
// - GP request ORs eight flags, no clear
// - Comparator flag persists until software clears
// - Software flag writes act like hardware
// - Poll last cycle using previous values
// - Block on active level, return, config write
// - Blocked requests are never remembered
// - Inserted call lasts four cycles
// - Response latency between five and thirteen
// - Enable register bit seven global enable
// - Level from low and high registers
`timescale 1ns/1ps
`include "pvic_map.svh"
module pvic_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Configuration registers
    input wire logic [7:0] irq_enable_reg,
    input wire logic [7:0] priority_low_reg,
    input wire logic [7:0] priority_high_reg,
    input wire logic ext0_type_sel,
    input wire logic ext1_type_sel,
    input wire logic [1:0] timer0_mode,
    // Request flags, already merged with software writes
    input wire pvic_pkg::pvic_flags_t flags,
    // Instruction sequencer
    input wire pvic_pkg::pvic_instr_t instr,
    // To sequencer
    output logic call_busy,
    output logic call_start,
    output logic [15:0] call_vector,
    output logic [3:0] active_levels,
    // Flag clears to the peripherals
    output pvic_pkg::pvic_hw_clr_t hw_clr
);
    // =================================================================
    // Request gathering
    logic [6:0] raw_req;
    logic [6:0] req_q;
    logic [6:0] req_d;
    logic [13:0] lvl;
    logic found;
    logic [2:0] idx;
    pvic_pkg::pvic_level_t win_lvl;

    always_comb begin
        raw_req[`PVIC_SRC_EXT0] = flags.ext0_request_flag;
        // mode 3 keeps timer zero silent
        raw_req[`PVIC_SRC_TMR0] = flags.timer0_overflow_flag
            && timer0_mode != `PVIC_TMR0_MODE3;
        raw_req[`PVIC_SRC_EXT1] = flags.ext1_request_flag;
        raw_req[`PVIC_SRC_TMR1] = flags.timer1_overflow_flag;
        raw_req[`PVIC_SRC_SER] = flags.uart_rx_flag || flags.uart_tx_flag
            || flags.spi_done_flag;
        raw_req[`PVIC_SRC_GP] = |flags.gp_pin_flags;
        raw_req[`PVIC_SRC_CMP] = flags.comparator_flag;
        req_d = raw_req & irq_enable_reg[6:0]
            & {7{irq_enable_reg[`PVIC_EN_GLOBAL_BIT]}};
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            req_q <= 7'h00;
        end else if (clk_en) begin
            req_q <= req_d;
        end
    end

    // =================================================================
    // Levels
    always_comb begin
        // high bit and low bit pair up
        for (int i = 0; i < 6; i++) begin
            lvl[2*i +: 2] = {priority_high_reg[i], priority_low_reg[i]};
        end
        lvl[13:12] = 2'h0;
    end

    pvic_arbiter u_arb (
        .req(req_q),
        .lvl(lvl),
        .found(found),
        .idx(idx),
        .win_lvl(win_lvl)
    );

    // =================================================================
    // Sequencer
    pvic_pkg::pvic_state_t state_q;
    pvic_pkg::pvic_state_t state_d;
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic [3:0] act_q;
    logic [3:0] act_d;
    logic [2:0] win_q;
    logic [2:0] win_d;
    logic start_q;
    logic start_d;
    logic [15:0] vec_q;
    logic [15:0] vec_d;
    pvic_pkg::pvic_hw_clr_t clr_q;
    pvic_pkg::pvic_hw_clr_t clr_d;
    logic [3:0] above;
    logic grant;
    logic [3:0] top_mask;

    always_comb begin
        // Levels at or above the winner that are in service block it
        above = 4'h0;
        for (int l = 0; l < 4; l++) begin
            above[l] = (2'(l) >= win_lvl);
        end
        // Clear the highest active level on return
        top_mask = 4'h0;
        for (int l = 0; l < 4; l++) begin
            if (act_q[l]) begin
                top_mask = 4'h1 << l;
            end
        end
    end

    // block on level, return, config write
    // each poll decided from flags registered the cycle before
    assign grant = (state_q == pvic_pkg::PVIC_IDLE) && instr.last_cycle
        && found && !(|(act_q & above)) && !instr.is_return
        && !instr.is_cfg_write;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        act_d = act_q;
        win_d = win_q;
        start_d = 1'b0;
        vec_d = vec_q;
        clr_d = '0;
        case (state_q)
            pvic_pkg::PVIC_IDLE: begin
                if (instr.last_cycle && instr.is_return) begin
                    act_d = act_q & ~top_mask;
                end
                if (grant) begin
                    act_d = act_q | (4'h1 << win_lvl);
                    win_d = idx;
                    start_d = 1'b1;
                    vec_d = `PVIC_VEC_BASE
                        + (16'(idx) << 3);
                    cnt_d = 3'h1;
                    state_d = pvic_pkg::PVIC_CALL;
                end
            end
            pvic_pkg::PVIC_CALL: begin
                // latency follows from poll plus call
                if (cnt_q == `PVIC_CALL_CYCLES) begin
                    state_d = pvic_pkg::PVIC_DONE;
                end else begin
                    cnt_d = cnt_q + 3'h1;
                end
            end
            pvic_pkg::PVIC_DONE: begin
                // Flags clear as the routine is entered
                // edge mode externals only
                clr_d.ext0_clr = (win_q == 3'(`PVIC_SRC_EXT0))
                    && ext0_type_sel;
                clr_d.ext1_clr = (win_q == 3'(`PVIC_SRC_EXT1))
                    && ext1_type_sel;
                clr_d.tmr0_clr = (win_q == 3'(`PVIC_SRC_TMR0));
                clr_d.tmr1_clr = (win_q == 3'(`PVIC_SRC_TMR1));
                state_d = pvic_pkg::PVIC_IDLE;
            end
            default: begin
                state_d = pvic_pkg::PVIC_IDLE;
            end
        endcase
    end

    // software writes reach us through the flag inputs
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_q <= pvic_pkg::PVIC_IDLE;
            cnt_q <= 3'h0;
            act_q <= 4'h0;
            win_q <= 3'h0;
            start_q <= 1'b0;
            vec_q <= `PVIC_VEC_RESET;
            clr_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            act_q <= act_d;
            win_q <= win_d;
            start_q <= start_d;
            vec_q <= vec_d;
            clr_q <= clr_d;
        end
    end

    logic busy_q;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            busy_q <= 1'b0;
        end else if (clk_en) begin
            busy_q <= (state_d == pvic_pkg::PVIC_CALL);
        end
    end

    assign call_busy = busy_q;
    assign call_start = start_q;
    assign call_vector = vec_q;
    assign active_levels = act_q;
    assign hw_clr = clr_q;
endmodule // pvic_ctrl

/* File: common/pvic_map.svh */
`ifndef PVIC_MAP_SVH
`define PVIC_MAP_SVH
// =====================================================================
// Vectors
`define PVIC_VEC_RESET 16'h0000
`define PVIC_VEC_BASE 16'h0003
`define PVIC_VEC_STEP 16'h0008
// =====================================================================
// Enable register fields
`define PVIC_EN_GLOBAL_BIT 7
`define PVIC_EN_RESET 8'h00
`define PVIC_PRIO_RESET 8'h00
// =====================================================================
// Sources, in vector order
`define PVIC_SRC_EXT0 0
`define PVIC_SRC_TMR0 1
`define PVIC_SRC_EXT1 2
`define PVIC_SRC_TMR1 3
`define PVIC_SRC_SER 4
`define PVIC_SRC_GP 5
`define PVIC_SRC_CMP 6
// =====================================================================
// Timing
`define PVIC_CALL_CYCLES 3'h4
`define PVIC_TMR0_MODE3 2'h3
`endif

/* File: common/pvic_pkg.sv */
package pvic_pkg;
    typedef logic [1:0] pvic_level_t;

    typedef struct packed {
        logic ext0_request_flag;
        logic timer0_overflow_flag;
        logic ext1_request_flag;
        logic timer1_overflow_flag;
        logic uart_rx_flag;
        logic uart_tx_flag;
        logic spi_done_flag;
        logic [7:0] gp_pin_flags;
        logic comparator_flag;
    } pvic_flags_t;

    typedef struct packed {
        logic ext0_clr;
        logic tmr0_clr;
        logic ext1_clr;
        logic tmr1_clr;
    } pvic_hw_clr_t;

    typedef struct packed {
        logic last_cycle;
        logic is_return;
        logic is_cfg_write;
    } pvic_instr_t;

    typedef enum logic [2:0] {
        PVIC_IDLE = 3'b001,
        PVIC_CALL = 3'b010,
        PVIC_DONE = 3'b100
    } pvic_state_t;
endpackage

/* File: rtl/pvic_arbiter.sv */
`timescale 1ns/1ps
`include "pvic_map.svh"
// Picks highest level, then lowest vector, among eligible requests
module pvic_arbiter (
    // Requests and levels
    input wire logic [6:0] req,
    input wire logic [13:0] lvl,
    // Result
    output logic found,
    output logic [2:0] idx,
    output pvic_pkg::pvic_level_t win_lvl
);
    always_comb begin
        found = 1'b0;
        idx = 3'h0;
        win_lvl = 2'h0;
        for (int i = 0; i < 7; i++) begin
            if (req[i] && (!found || lvl[2*i +: 2] > win_lvl)) begin
                found = 1'b1;
                idx = 3'(i);
                win_lvl = lvl[2*i +: 2];
            end
        end
    end
endmodule // pvic_arbiter

/* File: tb/pvic_monitor.sv */
`timescale 1ns/1ps
// =====================================================================
// Checker on the controller's ports
module pvic_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Watched ports
    input wire logic [7:0] irq_enable_reg,
    input wire pvic_pkg::pvic_instr_t instr,
    input wire logic call_busy,
    input wire logic call_start,
    input wire logic [15:0] call_vector,
    input wire logic [3:0] active_levels,
    input wire pvic_pkg::pvic_hw_clr_t hw_clr
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_call;
        call_busy [*4] ##1 !call_busy;
    endsequence
    property p_len;
        $rose(call_busy) |-> s_call;
    endproperty
    property p_start;
        $rose(call_busy) |-> call_start;
    endproperty
    property p_vec;
        call_start |-> call_vector[2:0] == 3'h3 && call_vector <= 16'h0033;
    endproperty
    // Clear pulse stands two cycles after the last busy cycle
    property p_clr;
        hw_clr != 4'h0 |-> $past(call_busy, 2) && !$past(call_busy);
    endproperty
    property p_gap;
        call_start |-> !$past(call_busy);
    endproperty
    property p_ga;
        (!irq_enable_reg[7]) [*4] |-> !call_start;
    endproperty
    property p_blk;
        instr.last_cycle && (instr.is_return || instr.is_cfg_write)
            |=> !call_start;
    endproperty
    property p_act;
        call_start |-> ##[0:6] active_levels != 4'h0;
    endproperty

    a_len: assert property (p_len)
        else $error("call length wrong");
    a_start: assert property (p_start)
        else $error("busy without start");
    a_vec: assert property (p_vec)
        else $error("bad vector");
    a_clr: assert property (p_clr)
        else $error("clear pulse misplaced");
    a_gap: assert property (p_gap)
        else $error("grant during call");
    a_ga: assert property (p_ga)
        else $error("call while globally off");
    a_blk: assert property (p_blk)
        else $error("call after blocking instruction");
    a_act: assert property (p_act)
        else $error("no level marked active");
endmodule // pvic_monitor

bind pvic_ctrl pvic_monitor u_mon (
    .core_clk(core_clk),
    .nrst(nrst),
    .irq_enable_reg(irq_enable_reg),
    .instr(instr),
    .call_busy(call_busy),
    .call_start(call_start),
    .call_vector(call_vector),
    .active_levels(active_levels),
    .hw_clr(hw_clr)
);

/* File: tb/pvic_periph.sv */
`timescale 1ns/1ps
// =====================================================================
// Peripheral flag holders facing the controller
module pvic_periph (
    // Clock
    input wire logic core_clk,
    // Software set and clear
    input wire logic [15:0] set_f,
    input wire logic [15:0] clr_f,
    // Clears from the controller
    input wire pvic_pkg::pvic_hw_clr_t hw_clr,
    // Flags
    output pvic_pkg::pvic_flags_t flags
);
    always_ff @(posedge core_clk) begin
        flags <= (flags | set_f) & ~(clr_f | {hw_clr, 12'h000});
    end
endmodule // pvic_periph

/* File: tb/pvic_ctrl_tb.sv */
`timescale 1ns/1ps
module pvic_ctrl_tb;
    logic core_clk, nrst, busy, start;
    logic ce, t1s;
    logic [7:0] en, plo, phi;
    logic [1:0] t0m;
    logic [15:0] vec, sf, cf;
    logic [3:0] act;
    pvic_pkg::pvic_flags_t flags;
    pvic_pkg::pvic_instr_t instr;
    pvic_pkg::pvic_hw_clr_t hw_clr;
    int bad_count, n_compared, i;
    logic [15:0] msk [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
        16'h0800, 16'h0002, 16'h0001};

    pvic_ctrl dut (.core_clk(core_clk), .nrst(nrst), .clk_en(ce),
        .irq_enable_reg(en), .priority_low_reg(plo),
        .priority_high_reg(phi), .ext0_type_sel(1'b1),
        .ext1_type_sel(t1s), .timer0_mode(t0m), .flags(flags),
        .instr(instr), .call_busy(busy), .call_start(start),
        .call_vector(vec), .active_levels(act), .hw_clr(hw_clr));
    pvic_periph u_per (.core_clk(core_clk), .set_f(sf), .clr_f(cf),
        .hw_clr(hw_clr), .flags(flags));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // =================================================================
    // Tasks
    task automatic chk(input logic [15:0] seen, exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic poll(input logic ret);
        @(posedge core_clk) instr <= {1'b1, ret, 1'b0};
        @(posedge core_clk) instr <= '0;
    endtask

    // Raise flags, poll once, then cancel them and return
    task automatic serve(input logic [15:0] m, input logic ret, hit,
            input logic [15:0] v, f);
        int k;
        @(posedge core_clk) sf <= m;
        @(posedge core_clk) sf <= '0;
        poll(ret);
        k = 0;
        #1;
        while (start !== 1'b1 && k < 20) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk({15'h0000, start}, {15'h0000, hit}, "call");
        if (hit) begin
            chk(vec, v, "vector");
        end
        repeat (6) @(posedge core_clk);
        // Clear pulses land on this edge; look once they have settled
        #1;
        chk(flags, f, "flags");
        @(posedge core_clk) cf <= '1;
        poll(1'b1);
        cf <= '0;
    endtask

    // Raise flags, poll once with the given return and write bits
    task automatic step(input logic [15:0] m, input logic ret, cfg, hit,
            input logic [15:0] v);
        int k;
        @(posedge core_clk) sf <= m;
        @(posedge core_clk) sf <= '0;
        @(posedge core_clk) instr <= {1'b1, ret, cfg};
        @(posedge core_clk) instr <= '0;
        k = 0;
        #1;
        while (start !== 1'b1 && k < 8) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk({15'h0000, start}, {15'h0000, hit}, "step call");
        if (hit) begin
            chk(vec, v, "step vector");
        end
        repeat (6) @(posedge core_clk);
    endtask

    task conclude;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // =================================================================
    // Tests
    initial begin
        nrst = 1'b0;
        en = 8'hFF;
        plo = 8'h00;
        phi = 8'h00;
        t0m = 2'h0;
        ce = 1'b1;
        t1s = 1'b1;
        sf = 16'h0000;
        cf = 16'hFFFF;
        instr = '0;
        bad_count = 0;
        n_compared = 0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        cf <= 16'h0000;
        @(posedge core_clk) #1;
        chk(vec, 16'h0000, "reset vector");
        chk({12'h000, act}, 16'h0000, "levels");
        for (i = 0; i < 7; i++) begin
            serve(msk[i], 1'b0, 1'b1, 16'h0003 + 16'(8 * i),
                msk[i] & 16'h0FFF);
        end
        serve(16'h8801, 1'b0, 1'b1, 16'h0003, 16'h0801);
        @(posedge core_clk) plo <= 8'h20;
        phi <= 8'h20;
        serve(16'h8002, 1'b0, 1'b1, 16'h002B, 16'h8002);
        serve(16'h8000, 1'b1, 1'b0, 16'h0000, 16'h8000);
        @(posedge core_clk) t0m <= 2'h3;
        serve(16'h4000, 1'b0, 1'b0, 16'h0000, 16'h4000);
        // Nesting: external one moves to level one
        @(posedge core_clk) plo <= 8'h24;
        step(16'h8000, 1'b0, 1'b0, 1'b1, 16'h0003);
        chk({12'h000, act}, 16'h0001, "level zero active");
        step(16'h2000, 1'b0, 1'b0, 1'b1, 16'h0013);
        chk({12'h000, act}, 16'h0003, "nested levels");
        step(16'h8000, 1'b0, 1'b0, 1'b0, 16'h0000);
        step(16'h0000, 1'b1, 1'b0, 1'b0, 16'h0000);
        chk({12'h000, act}, 16'h0001, "level after return");
        step(16'h0000, 1'b1, 1'b0, 1'b0, 16'h0000);
        chk({12'h000, act}, 16'h0000, "levels after returns");
        step(16'h0000, 1'b0, 1'b1, 1'b0, 16'h0000);
        @(posedge core_clk) cf <= 16'h8000;
        @(posedge core_clk) cf <= 16'h0000;
        step(16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000);
        // Level mode keeps the external flag through the call
        @(posedge core_clk) t1s <= 1'b0;
        step(16'h2000, 1'b0, 1'b0, 1'b1, 16'h0013);
        #1 chk(flags, 16'h2000, "level flag kept");
        @(posedge core_clk) cf <= 16'h2000;
        @(posedge core_clk) cf <= 16'h0000;
        step(16'h0000, 1'b1, 1'b0, 1'b0, 16'h0000);
        // Frozen controller must not answer until enabled again
        @(posedge core_clk) ce <= 1'b0;
        step(16'h8000, 1'b0, 1'b0, 1'b0, 16'h0000);
        @(posedge core_clk) ce <= 1'b1;
        step(16'h0000, 1'b0, 1'b0, 1'b1, 16'h0003);
        step(16'h0000, 1'b1, 1'b0, 1'b0, 16'h0000);
        @(posedge core_clk) en <= 8'h7F;
        serve(16'h8000, 1'b0, 1'b0, 16'h0000, 16'h8000);
        conclude();
    end

    // Cut a hang short well past the expected run
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        conclude();
    end
endmodule // pvic_ctrl_tb
